// *** hw/socket_ctrl_pkg.sv ***
// Constants and types shared by the socket voltage and clock control block.
package socket_ctrl_pkg;

	// Register addresses on the plain register port.
	localparam logic [7:0] FORCE_ADDR = 8'h0C;
	localparam logic [7:0] SOCK_CTRL_ADDR = 8'h10;
	localparam logic [7:0] DIAG_ADDR = 8'h14;
	localparam logic [7:0] STATUS_ADDR = 8'h18;

	// Socket voltage and clock control field layout.
	localparam int RSVD_HIGH_LSB = 12;
	localparam int VID_ACT_BIT = 11;
	localparam int STD_FLAG_BIT = 10;
	localparam int VID_EN_BIT = 9;
	localparam int RSVD_MID_BIT = 8;
	localparam int STOP_POL_BIT = 7;
	localparam int SUPPLY_LSB = 4;
	localparam int RSVD_LOW_BIT = 3;
	localparam int PROG_LSB = 0;
	localparam int FIELD_W = 3;
	localparam logic [31:0] SOCK_CTRL_RESET = 32'h0000_0400;

	// Force register and diagnostic register fields.
	localparam int RETEST_BIT = 14;
	localparam int FORCE_LSB = 10;
	localparam int FORCE_W = 4;
	localparam int DIAG_STD_BIT = 0;

	// Status register fields.
	localparam int ST_ENABLED_BIT = 0;
	localparam int ST_REFUSED_BIT = 1;
	localparam int ST_SENSING_BIT = 2;
	localparam int ST_CAPS_LSB = 4;

	// Voltage request codes; 3'h6, 3'h7 and supply 3'h1 are reserved.
	localparam logic [2:0] V_OFF = 3'h0;
	localparam logic [2:0] V_12 = 3'h1;
	localparam logic [2:0] V_5 = 3'h2;
	localparam logic [2:0] V_33 = 3'h3;
	localparam logic [2:0] V_X = 3'h4;
	localparam logic [2:0] V_Y = 3'h5;

	// Card capability vector order.
	localparam int CAP_5 = 0;
	localparam int CAP_33 = 1;
	localparam int CAP_X = 2;
	localparam int CAP_Y = 3;

	// Card re-interrogation time.
	localparam int CLK_PERIOD_NS = 50;
	localparam int SENSE_TIME_NS = 500;
	localparam int SENSE_CYCLES = (SENSE_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int SENSE_CNT_W = 4;

	// Number of pin inputs passed through the synchroniser.
	localparam int PIN_W = 7;

	typedef enum logic {sense_idle, sense_run} sense_state_t;

endpackage : socket_ctrl_pkg

// *** hw/pin_sync3.sv ***
// Three-stage pin synchroniser that accepts a change once stages agree.
`timescale 1ns/10ps
`default_nettype none
module pin_sync3 #(
	parameter int WIDTH = 1
) (
	// Clock and reset.
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Pins in, filtered levels out.
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] level_o
);

	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
		logic [WIDTH-1:0] third;
		logic [WIDTH-1:0] level;
	} sync_state_t;

	sync_state_t s;
	sync_state_t next_s;

	// The first stage feeds only the second stage.
	always_comb
	begin
		next_s = s;
		next_s.first = pin_i;
		next_s.second = s.first;
		next_s.third = s.second;
		for (int i = 0; i < WIDTH; i++)
		begin
			if (s.second[i] == s.third[i])
			begin
				next_s.level[i] = s.third[i];
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			s <= '0;
		end
		else
		begin
			s <= next_s;
		end
	end

	assign level_o = s.level;

endmodule : pin_sync3
`default_nettype wire

// *** hw/socket_ctrl.sv ***
// Socket voltage and clock control register with card supply gating.
//
// How it works
// - Bits 31 to 12 of the socket control register read zero and writes there change nothing.
// - Bit 8 is reserved, reads zero and a write to it is dropped.
// - Bit 3 is reserved and reads zero.
// - The video activity flag at bit 11 reads the state of the video enable.
// - The standard video model flag at bit 10 reads one while the diagnostic model enable is clear.
// - After reset the register reads 0x00000400 with every request field zero.
// - Bit 9 is a read/write video path enable for this socket.
// - With policy bit 7 clear the card clock may stop only when idle and the host clock is stopping.
// - With policy bit 7 set the card clock may stop whenever the socket is idle.
// - Bits 6 to 4 request the card supply: off, 5 V, 3.3 V, X.X V or Y.Y V, other codes reserved.
// - Bits 2 to 0 request the programming voltage: off, 12 V, 5 V, 3.3 V, X.X V or Y.Y V.
// - Supply is applied only when the request suits the detected or forced card type, else it is refused while a card is present.
// - The retest bit of the force register re-senses the card and then enables this register.
// - Any forced card type bit disables this register until re-sensing enables it.
`timescale 1ns/10ps
`default_nettype none
module socket_ctrl
	import socket_ctrl_pkg::*;
(
	// Clock and reset.
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Register port.
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// Card sense and clock-run pins.
	input wire logic card_present_i,
	input wire logic card_5v_i,
	input wire logic card_3v_i,
	input wire logic card_xv_i,
	input wire logic card_yv_i,
	input wire logic socket_idle_i,
	input wire logic host_clk_stopping_i,
	// Power switch and video path.
	output logic [2:0] card_supply_apply_o,
	output logic [2:0] program_voltage_apply_o,
	output logic supply_refused_o,
	output logic video_path_enable_o,
	// Card clock-run permission.
	output logic card_clock_stop_allow_o
);

	typedef struct packed {
		sense_state_t mode;
		logic [SENSE_CNT_W-1:0] sense_count;
		logic enabled;
		logic [FORCE_W-1:0] caps;
		logic [FORCE_W-1:0] forced;
		logic present_d;
		logic video_path_enable;
		logic card_clock_stop_policy;
		logic [FIELD_W-1:0] card_supply_request;
		logic [FIELD_W-1:0] program_voltage_request;
		logic standard_video_model_enable;
		logic [31:0] rdata;
		logic [FIELD_W-1:0] supply_out;
		logic [FIELD_W-1:0] prog_out;
		logic refused;
		logic video_out;
		logic clk_allow;
	} state_t;

	state_t s;
	state_t next_s;
	logic [PIN_W-1:0] pins;
	logic present;
	logic [FORCE_W-1:0] detected;
	logic idle;
	logic host_stopping;
	logic supply_ok;
	logic prog_ok;

	// Says whether a voltage code suits the card capabilities.
	function automatic logic voltage_ok(input logic [FIELD_W-1:0] code,
		input logic [FORCE_W-1:0] caps, input logic allow_12);
		logic ok;
		ok = 1'b0;
		unique case (code)
			V_OFF: ok = 1'b1;
			V_12: ok = allow_12;
			V_5: ok = caps[CAP_5];
			V_33: ok = caps[CAP_33];
			V_X: ok = caps[CAP_X];
			V_Y: ok = caps[CAP_Y];
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction : voltage_ok

	// Builds the socket control word from the stored fields.
	function automatic logic [31:0] sock_word(input state_t st);
		logic [31:0] w;
		w = '0;
		w[VID_ACT_BIT] = st.video_path_enable;
		w[STD_FLAG_BIT] = !st.standard_video_model_enable;
		w[VID_EN_BIT] = st.video_path_enable;
		w[STOP_POL_BIT] = st.card_clock_stop_policy;
		w[SUPPLY_LSB +: FIELD_W] = st.card_supply_request;
		w[PROG_LSB +: FIELD_W] = st.program_voltage_request;
		return w;
	endfunction : sock_word

	pin_sync3 #(
		.WIDTH(PIN_W)
	) pin_sync3_inst (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.pin_i({host_clk_stopping_i, socket_idle_i, card_yv_i, card_xv_i,
			card_3v_i, card_5v_i, card_present_i}),
		.level_o(pins)
	);

	assign present = pins[0];
	assign detected = pins[4:1];
	assign idle = pins[5];
	assign host_stopping = pins[6];

	// Supply goes on only for an enabled register, a card, and a fit code.
	assign supply_ok = s.enabled && present
		&& voltage_ok(s.card_supply_request, s.caps, 1'b0);
	assign prog_ok = supply_ok
		&& voltage_ok(s.program_voltage_request, s.caps, 1'b1);

	always_comb
	begin
		next_s = s;
		next_s.rdata = '0;
		next_s.present_d = present;

		if (rd_i)
		begin
			case (addr_i)
				SOCK_CTRL_ADDR: next_s.rdata = sock_word(s);
				DIAG_ADDR: next_s.rdata[DIAG_STD_BIT] =
					s.standard_video_model_enable;
				STATUS_ADDR:
				begin
					next_s.rdata[ST_ENABLED_BIT] = s.enabled;
					next_s.rdata[ST_REFUSED_BIT] = s.refused;
					next_s.rdata[ST_SENSING_BIT] = (s.mode == sense_run);
					next_s.rdata[ST_CAPS_LSB +: FORCE_W] = s.caps;
				end
				default: next_s.rdata = '0;
			endcase
		end

		unique case (s.mode)
			sense_idle:
			begin
				next_s.sense_count = '0;
			end
			sense_run:
			begin
				if (s.sense_count <= SENSE_CNT_W'(1))
				begin
					next_s.mode = sense_idle;
					next_s.caps = detected | s.forced;
					next_s.enabled = 1'b1;
				end
				else
				begin
					next_s.sense_count = s.sense_count - SENSE_CNT_W'(1);
				end
			end
		endcase

		// Insertion starts a full card sense and removal forgets the card
		// type; this follows the sense machine so the count is not lost.
		if (present && !s.present_d)
		begin
			next_s.mode = sense_run;
			next_s.sense_count = SENSE_CNT_W'(SENSE_CYCLES);
		end
		else if (!present)
		begin
			next_s.caps = '0;
		end

		if (wr_i)
		begin
			// Only the writable fields are stored; reserved and flag bits drop.
			if (addr_i == SOCK_CTRL_ADDR && s.enabled)
			begin
				next_s.video_path_enable = wdata_i[VID_EN_BIT];
				next_s.card_clock_stop_policy = wdata_i[STOP_POL_BIT];
				next_s.card_supply_request =
					wdata_i[SUPPLY_LSB +: FIELD_W];
				next_s.program_voltage_request =
					wdata_i[PROG_LSB +: FIELD_W];
			end
			if (addr_i == DIAG_ADDR)
			begin
				next_s.standard_video_model_enable = wdata_i[DIAG_STD_BIT];
			end
			if (addr_i == FORCE_ADDR)
			begin
				if (|wdata_i[FORCE_LSB +: FORCE_W])
				begin
					next_s.forced = wdata_i[FORCE_LSB +: FORCE_W];
					next_s.enabled = 1'b0;
				end
				if (wdata_i[RETEST_BIT])
				begin
					next_s.mode = sense_run;
					next_s.sense_count = SENSE_CNT_W'(SENSE_CYCLES);
				end
			end
		end

		next_s.supply_out = supply_ok ? s.card_supply_request : V_OFF;
		next_s.prog_out = prog_ok ? s.program_voltage_request : V_OFF;
		next_s.refused = present && !(supply_ok && prog_ok)
			&& (s.card_supply_request != V_OFF
			|| s.program_voltage_request != V_OFF);
		next_s.video_out = s.video_path_enable;
		next_s.clk_allow = idle
			&& (s.card_clock_stop_policy || host_stopping);
	end

	// Reset leaves every request zero, so the word reads 0x00000400.
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			s <= '0;
			s.mode <= sense_idle;
			s.enabled <= 1'b1;
		end
		else
		begin
			s <= next_s;
		end
	end

	assign rdata_o = s.rdata;
	assign card_supply_apply_o = s.supply_out;
	assign program_voltage_apply_o = s.prog_out;
	assign supply_refused_o = s.refused;
	assign video_path_enable_o = s.video_out;
	assign card_clock_stop_allow_o = s.clk_allow;

	localparam int sense_lo = SENSE_CYCLES;
	localparam int sense_hi = SENSE_CYCLES + 1;

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);

	logic sock_rd;
	logic sock_wr;
	logic force_wr;
	assign sock_rd = rd_i && addr_i == SOCK_CTRL_ADDR;
	assign sock_wr = wr_i && addr_i == SOCK_CTRL_ADDR && s.enabled;
	assign force_wr = wr_i && addr_i == FORCE_ADDR;

	high_bits_zero_a: assert property (sock_rd |=>
		rdata_o[31:RSVD_HIGH_LSB] == '0)
		else $error("upper socket control bits not zero");

	mid_reserved_a: assert property (sock_rd |=>
		!rdata_o[RSVD_MID_BIT])
		else $error("reserved bit 8 read as one");

	low_reserved_a: assert property (sock_rd |=>
		!rdata_o[RSVD_LOW_BIT])
		else $error("reserved bit 3 read as one");

	activity_flag_a: assert property (sock_rd |=>
		rdata_o[VID_ACT_BIT] == rdata_o[VID_EN_BIT])
		else $error("video activity flag differs from enable");

	std_flag_a: assert property (sock_rd && !s.standard_video_model_enable
		|=> rdata_o[STD_FLAG_BIT])
		else $error("standard model flag not set");

	reset_value_a: assert property (@(posedge clock_i)
		$rose(rst_n_i) |-> sock_word(s) == SOCK_CTRL_RESET)
		else $error("socket control word wrong after reset");

	enable_store_a: assert property (sock_wr |=> ##1
		video_path_enable_o == $past(wdata_i[VID_EN_BIT], 2))
		else $error("video enable write not applied");

	fields_store_a: assert property (sock_wr |=>
		s.card_supply_request == $past(wdata_i[SUPPLY_LSB +: FIELD_W])
		&& s.program_voltage_request == $past(wdata_i[PROG_LSB +: FIELD_W]))
		else $error("voltage request fields not stored");

	clock_policy_a: assert property (1'b1 |=>
		card_clock_stop_allow_o == $past(idle
		&& (s.card_clock_stop_policy || host_stopping)))
		else $error("card clock stop permission wrong");

	supply_gate_a: assert property (card_supply_apply_o != V_OFF |->
		$past(s.enabled && present
		&& voltage_ok(s.card_supply_request, s.caps, 1'b0)))
		else $error("supply applied to an unsuited card");

	retest_enable_a: assert property (force_wr && wdata_i[RETEST_BIT]
		&& !(present && !s.present_d) |-> ##[sense_lo:sense_hi]
		s.enabled)
		else $error("retest did not enable the register");

	force_disable_a: assert property (force_wr
		&& |wdata_i[FORCE_LSB +: FORCE_W] && !wdata_i[RETEST_BIT]
		&& s.mode == sense_idle |=> !s.enabled)
		else $error("forced card type did not disable");

	refused_prog_off_a: assert property (supply_refused_o |->
		program_voltage_apply_o == V_OFF)
		else $error("programming voltage applied to a refused request");

	legal_codes_a: assert property (
		card_supply_apply_o != V_12 && card_supply_apply_o <= V_Y
		&& program_voltage_apply_o <= V_Y)
		else $error("reserved voltage code applied");

	blocked_write_a: assert property (
		wr_i && addr_i == SOCK_CTRL_ADDR && !s.enabled
		|=> $stable(s.card_supply_request) && $stable(s.video_path_enable))
		else $error("write changed a disabled register");

	insert_sense_a: assert property (present && !s.present_d |=>
		s.mode == sense_run && s.sense_count == SENSE_CNT_W'(SENSE_CYCLES))
		else $error("card insertion did not start a full sense");

	disabled_supply_a: assert property (!s.enabled |=>
		card_supply_apply_o == V_OFF)
		else $error("supply applied while register disabled");

	retest_seen_c: cover property (force_wr && wdata_i[RETEST_BIT]
		##[sense_lo:sense_hi] s.enabled);
	supply_on_c: cover property (card_supply_apply_o == V_33);
	refused_c: cover property ($rose(supply_refused_o));
	prog_12v_c: cover property (program_voltage_apply_o == V_12);

endmodule : socket_ctrl
`default_nettype wire

// *** test/card_socket_model.sv ***
// Card socket stand-in that drives the presence and capability pins.
`timescale 1ns/10ps
`default_nettype none
module card_socket_model (
	// Card control from the bench.
	input wire logic insert_i,
	input wire logic [3:0] caps_i,
	// Socket pins.
	output logic present_o,
	output logic [3:0] cap_o
);
	// Open contacts read low, so an empty socket shows no capability.
	assign present_o = insert_i;
	assign cap_o = insert_i ? caps_i : 4'h0;
endmodule : card_socket_model
`default_nettype wire

// *** test/test_socket_ctrl.sv ***
// Self-checking bench for the socket voltage and clock control block.
`timescale 1ns/10ps
`default_nettype none
module test_socket_ctrl
	import socket_ctrl_pkg::*;
;
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic idle = 1'b0;
	logic host = 1'b0;
	logic insert = 1'b0;
	logic [3:0] caps = 4'h0;
	logic present;
	logic [3:0] cap;
	logic [31:0] rdata_o;
	logic [2:0] supply;
	logic [2:0] prog;
	logic refused;
	logic video;
	logic allow;
	logic [31:0] rv;
	int errors = 0;
	int total_checks = 0;
	int cycles = 0;

	card_socket_model card_socket_model_inst (
		.insert_i(insert),
		.caps_i(caps),
		.present_o(present),
		.cap_o(cap)
	);

	socket_ctrl socket_ctrl_inst (
		.clock_i(clock_i), .rst_n_i(rst_n_i),
		.addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.card_present_i(present),
		.card_5v_i(cap[CAP_5]), .card_3v_i(cap[CAP_33]),
		.card_xv_i(cap[CAP_X]), .card_yv_i(cap[CAP_Y]),
		.socket_idle_i(idle), .host_clk_stopping_i(host),
		.card_supply_apply_o(supply),
		.program_voltage_apply_o(prog),
		.supply_refused_o(refused),
		.video_path_enable_o(video),
		.card_clock_stop_allow_o(allow)
	);

	always #25 clock_i = ~clock_i;

	always @(posedge clock_i)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			errors++;
			complete_run();
		end
	end

	task complete_run();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run

	task check_reg(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected at %0t: word %h not %h", $time, got, exp);
		end
	endtask : check_reg

	task check_pin(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected at %0t: pins %h not %h", $time, got, exp);
		end
	endtask : check_pin

	task settle(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask : settle

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 rv = rdata_o;
	endtask : rd

	task test_reset();
		rd(SOCK_CTRL_ADDR);
		check_reg(rv, SOCK_CTRL_RESET);
		settle(1);
		check_reg(rdata_o, 32'h0);
		check_pin({video, refused, supply, prog}, 8'h00);
		$display("reset test done");
	endtask : test_reset

	task test_fields();
		wr(SOCK_CTRL_ADDR, 32'hFFFF_FFFF);
		rd(SOCK_CTRL_ADDR);
		check_reg(rv, 32'h0000_0EF7);
		check_pin({7'h0, video}, 8'h01);
		wr(8'h40, 32'h0);
		rd(8'h40);
		check_reg(rv, 32'h0);
		rd(SOCK_CTRL_ADDR);
		check_reg(rv, 32'h0000_0EF7);
		wr(SOCK_CTRL_ADDR, 32'h0);
		rd(SOCK_CTRL_ADDR);
		check_reg(rv, 32'h0000_0400);
		check_pin({7'h0, video}, 8'h00);
		$display("field test done");
	endtask : test_fields

	task test_model();
		wr(DIAG_ADDR, 32'h1);
		rd(DIAG_ADDR);
		check_reg(rv, 32'h0000_0001);
		rd(SOCK_CTRL_ADDR);
		check_reg(rv, 32'h0);
		wr(DIAG_ADDR, 32'h0);
		rd(SOCK_CTRL_ADDR);
		check_reg(rv, 32'h0000_0400);
		$display("model flag test done");
	endtask : test_model

	task test_clock();
		for (int i = 0; i < 8; i++)
		begin
			wr(SOCK_CTRL_ADDR, 32'(i[2]) << STOP_POL_BIT);
			idle <= i[0];
			host <= i[1];
			settle(8);
			check_pin({7'h0, allow}, {7'h0, i[0] & (i[2] | i[1])});
		end
		$display("clock policy test done");
	endtask : test_clock

	task test_supply();
		logic ok;
		@(posedge clock_i);
		insert <= 1'b1;
		caps <= 4'hF;
		settle(20);
		for (int s = 0; s < 8; s++)
		begin
			ok = (s == 0) || (s >= 2 && s <= 5);
			wr(SOCK_CTRL_ADDR, 32'(s) << SUPPLY_LSB);
			settle(3);
			check_pin({1'b0, refused, supply, prog},
				ok ? {2'b0, 3'(s), 3'h0} : 8'h40);
		end
		for (int p = 0; p < 6; p++)
		begin
			wr(SOCK_CTRL_ADDR, {25'h0, V_33, 1'b0, 3'(p)});
			settle(3);
			check_pin({2'b0, supply, prog}, {2'b0, V_33, 3'(p)});
		end
		@(posedge clock_i);
		insert <= 1'b0;
		settle(8);
		@(posedge clock_i);
		caps <= 4'h2;
		insert <= 1'b1;
		settle(20);
		wr(SOCK_CTRL_ADDR, {25'h0, V_5, 4'h0});
		settle(3);
		check_pin({1'b0, refused, supply, prog}, 8'h40);
		wr(SOCK_CTRL_ADDR, {25'h0, V_33, 4'h0});
		settle(3);
		check_pin({1'b0, refused, supply, prog}, 8'h18);
		$display("supply test done");
	endtask : test_supply

	task test_force();
		wr(FORCE_ADDR, 32'h1 << FORCE_LSB);
		wr(SOCK_CTRL_ADDR, 32'h0000_0200);
		rd(SOCK_CTRL_ADDR);
		check_reg(rv, 32'h0000_0430);
		rd(STATUS_ADDR);
		check_reg(rv, 32'h0000_0022);
		settle(2);
		check_pin({5'h0, supply}, 8'h00);
		wr(FORCE_ADDR, 32'h1 << RETEST_BIT);
		rd(STATUS_ADDR);
		check_reg(rv, 32'h0000_0026);
		settle(20);
		rd(STATUS_ADDR);
		check_reg(rv, 32'h0000_0031);
		wr(SOCK_CTRL_ADDR, 32'h0000_0200);
		rd(SOCK_CTRL_ADDR);
		check_reg(rv, 32'h0000_0E00);
		$display("force test done");
	endtask : test_force

	initial
	begin
		repeat (10) @(posedge clock_i);
		rst_n_i <= 1'b1;
		test_reset();
		test_fields();
		test_model();
		test_clock();
		test_supply();
		test_force();
		complete_run();
	end
endmodule : test_socket_ctrl
`default_nettype wire
